// ===== rtl/seq_pkg.sv
package seq_pkg;

  localparam int NUM_IDS   = 32;
  localparam int SLOT_W    = 5;
  localparam int NUM_REGS  = 11;
  localparam int NUM_GPO   = 5;
  // id map: 0..10 regulators, 11..20 gpo rise/fall pairs, 21 wait, 22 pd
  localparam int ID_GPO_BASE = 11;
  localparam int ID_WAIT     = 21;
  localparam int ID_PD       = 22;

  // register map, word-indexed plain port
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_PTRS      = 8'h01;
  localparam logic [7:0] ADDR_TIMER     = 8'h02;
  localparam logic [7:0] ADDR_SEQCTL    = 8'h03;
  localparam logic [7:0] ADDR_KEEPON    = 8'h04;
  localparam logic [7:0] ADDR_PINCTL    = 8'h05;
  localparam logic [7:0] ADDR_STATUS    = 8'h06;
  localparam logic [7:0] ADDR_OUTS      = 8'h07;
  localparam logic [7:0] ADDR_TIMER_DEF = 8'h08;
  localparam logic [7:0] ADDR_SLOT_BASE = 8'h20;

  // control register bit positions
  localparam int CTRL_DOM1       = 0;
  localparam int CTRL_DOM2       = 1;
  localparam int CTRL_DOM3       = 2;
  localparam int CTRL_AUTO_BOOT  = 3;
  localparam int CTRL_DEF_SLOT   = 4;
  localparam int CTRL_STANDBY    = 5;
  localparam int CTRL_SHUTDOWN   = 6;
  localparam int CTRL_RES_BEFORE = 7;
  localparam int CTRL_FB_CFG     = 8;
  localparam int CTRL_DONE_EN    = 9;

  localparam logic [9:0] CTRL_RESET = 10'h018;

  // timing: one unit of delay field = 32 us
  localparam int CLK_MHZ         = 100;
  localparam int UNIT_US         = 32;
  localparam int UNIT_CYC        = UNIT_US * CLK_MHZ;
  localparam int SLOT_DELAY_US   = 128;
  localparam int SLOT_DELAY_MAX_US = 8000;
  localparam logic [7:0] SLOT_DELAY_DEF = 8'(SLOT_DELAY_US / UNIT_US);
  localparam logic [7:0] IDLE_DELAY_DEF = 8'h04;
  localparam logic [7:0] DELAY_MAX =
    8'(SLOT_DELAY_MAX_US / UNIT_US);
  localparam int RESET_TIMER_US  = 1024;
  localparam int RESET_TIMER_CYC = RESET_TIMER_US * CLK_MHZ;

  localparam logic [4:0] DOM1_END_DEF  = 5'h04;
  localparam logic [4:0] DOM2_END_DEF  = 5'h08;
  localparam logic [4:0] DOM3_END_DEF  = 5'h0c;
  localparam logic [4:0] PARTIAL_DOWN_PTR_DEF = 5'h02;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [4:0] dom1_end;
    logic [4:0] dom2_end;
    logic [4:0] dom3_end;
    logic [4:0] partial_down_ptr;
  } ptrs_t;

endpackage : seq_pkg

// ===== rtl/supply_slot_sequencer.sv
`timescale 1ns/1ps
// Functional notes
// - all ids sharing a slot are acted on together in one step.
// - empty slot does nothing, waits the idle slot delay only.
// - ids outside slots 0..domain3 end are never sequenced.
// - power-up starts at slot 0; default slot enables, or with seq_ctl bit clear only configures.
// - regulators enabled on power-up select the active voltage setting.
// - default slot enable cleared skips slot 0 entirely.
// - autonomous boot with domain1 enable raises ready then goes to slot 1.
// - without autonomous boot, wait for domain1 enable; a wakeup alone does not start.
// - at domain1 end without domain2 enable, drop ready, maybe done event.
// - after domain1 wait for domain2 enable, raise ready, walk domain2.
// - at domain2 end drop ready unless domain3, done, start watchdog.
// - domain3 enable walks to domain3 end, ready held, done at end.
// - slot delay default 128 us, settable 32 us to 8 ms.
// - delay fields reload from stored defaults when domain1 powers up.
// - power-down walks slots in reverse, ready held, done at target.
// - keep-on supplies move to sleep voltage instead of switching off.
// - pin-controlled regulators keep enable and voltage selection.
// - domain3 clear stops at domain2 end; domain2 clear at domain1 end.
// - domain1 clear goes to slot 0, or partial-down ptr with standby.
// - wakeups accepted only at slot 0 or partial-down pointer.
// - shutdown powers down to slot 0 then forces reset mode.
// - reset-before-down asserts host reset; reset timer releases it.
// - slot array holds 32 sequencer ids.
module supply_slot_sequencer (
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        dom1_pin_in,
  input  wire logic        dom2_pin_in,
  input  wire logic        dom3_pin_in,
  input  wire logic        wakeup_in,
  input  wire logic        alive_in,
  output logic [31:0]      rdata_out,
  output logic [10:0]      reg_enable_out,
  output logic [10:0]      reg_vsel_sleep_out,
  output logic [4:0]       gpo_out,
  output logic             pd_active_out,
  output logic             ready_out,
  output logic             done_event_out,
  output logic             host_reset_b_out,
  output logic             watchdog_start_out,
  output logic             reset_mode_out
);

  typedef enum logic [2:0] {
    ST_HOLD, ST_UP, ST_IDLE, ST_DOWN, ST_RESET
  } state_t;

  //////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta;
  logic rst_b;

  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_meta <= 1'b0;
      rst_b    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_b    <= rst_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [9:0]  ctrl;
  seq_pkg::ptrs_t ptrs;
  logic [7:0]  slot_delay;
  logic [7:0]  idle_slot_delay;
  logic [7:0]  slot_delay_def;
  logic [7:0]  idle_delay_def;
  logic [10:0] seq_ctl;
  logic [10:0] keep_on;
  logic [10:0] pin_ctl;
  logic [4:0]  slot_of [seq_pkg::NUM_IDS];
  logic        reload_delays;

  state_t      state;
  logic [4:0]  pos;
  logic [4:0]  target;
  logic        shutdown_pend;

  // clamp a delay field to its legal 32 us .. 8 ms range
  function automatic logic [7:0] clamp_delay(input logic [7:0] v);
    if (v == 8'h00)
      return 8'h01;
    else if (v > seq_pkg::DELAY_MAX)
      return seq_pkg::DELAY_MAX;
    else
      return v;
  endfunction : clamp_delay

  // control and pointers; shutdown bit self-clears once taken
  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl           <= seq_pkg::CTRL_RESET;
      ptrs           <= {seq_pkg::DOM1_END_DEF, seq_pkg::DOM2_END_DEF,
                         seq_pkg::DOM3_END_DEF, seq_pkg::PARTIAL_DOWN_PTR_DEF};
      seq_ctl        <= 11'h7ff;
      keep_on        <= 11'h000;
      pin_ctl        <= 11'h000;
      slot_delay_def <= seq_pkg::SLOT_DELAY_DEF;
      idle_delay_def <= seq_pkg::IDLE_DELAY_DEF;
    end
    else
    begin
      if (wr_in)
      begin
        case (addr_in)
          seq_pkg::ADDR_CTRL:      ctrl <= wdata_in[9:0];
          seq_pkg::ADDR_PTRS:      ptrs <= wdata_in[19:0];
          seq_pkg::ADDR_SEQCTL:    seq_ctl <= wdata_in[10:0];
          seq_pkg::ADDR_KEEPON:    keep_on <= wdata_in[10:0];
          seq_pkg::ADDR_PINCTL:    pin_ctl <= wdata_in[10:0];
          seq_pkg::ADDR_TIMER_DEF:
          begin
            slot_delay_def <= clamp_delay(wdata_in[7:0]);
            idle_delay_def <= clamp_delay(wdata_in[15:8]);
          end
          default: ;
        endcase
      end
      if (shutdown_pend)
        ctrl[seq_pkg::CTRL_SHUTDOWN] <= 1'b0;
    end
  end

  // live delay fields, reloaded from defaults at each domain1 start
  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slot_delay      <= seq_pkg::SLOT_DELAY_DEF;
      idle_slot_delay <= seq_pkg::IDLE_DELAY_DEF;
    end
    else if (reload_delays)
    begin
      slot_delay      <= slot_delay_def;
      idle_slot_delay <= idle_delay_def;
    end
    else if (wr_in && addr_in == seq_pkg::ADDR_TIMER)
    begin
      slot_delay      <= clamp_delay(wdata_in[7:0]);
      idle_slot_delay <= clamp_delay(wdata_in[15:8]);
    end
  end

  // slot pointer array
  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < seq_pkg::NUM_IDS; i++)
        slot_of[i] <= 5'h1f;
    end
    else if (wr_in && addr_in[7:5] == seq_pkg::ADDR_SLOT_BASE[7:5])
      slot_of[addr_in[4:0]] <= wdata_in[4:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // domain enables: pin or register
  logic dom1_en;
  logic dom2_en;
  logic dom3_en;
  assign dom1_en = ctrl[seq_pkg::CTRL_DOM1] | dom1_pin_in;
  assign dom2_en = ctrl[seq_pkg::CTRL_DOM2] | dom2_pin_in;
  assign dom3_en = ctrl[seq_pkg::CTRL_DOM3] | dom3_pin_in;

  // desired resting slot from enables
  logic [4:0] want;
  always_comb
  begin
    if (ctrl[seq_pkg::CTRL_SHUTDOWN] || shutdown_pend || !dom1_en)
      want = (ctrl[seq_pkg::CTRL_STANDBY] && !shutdown_pend &&
              !ctrl[seq_pkg::CTRL_SHUTDOWN]) ? ptrs.partial_down_ptr : 5'h00;
    else if (!dom2_en)
      want = ptrs.dom1_end;
    else if (!dom3_en)
      want = ptrs.dom2_end;
    else
      want = ptrs.dom3_end;
  end

  // which ids sit in the slot being processed
  logic [seq_pkg::NUM_IDS-1:0] hit;
  logic slot_empty;
  generate
    for (genvar g = 0; g < seq_pkg::NUM_IDS; g++)
    begin : g_hit
      assign hit[g] = (slot_of[g] == pos) &&
                      (slot_of[g] <= ptrs.dom3_end);
    end
  endgenerate
  assign slot_empty = (hit == '0);

  //////////////////////////////////////////////////////////////////////////
  // step timer: one unit pulse per 32 us, then delay count
  logic [11:0] unit_cnt;
  logic        unit_tick;
  logic [7:0]  delay_cnt;
  logic        step_go;
  logic        step_due;
  logic        moving;

  assign moving    = (state == ST_UP) || (state == ST_DOWN);
  assign unit_tick = (unit_cnt == 12'(seq_pkg::UNIT_CYC - 1));
  assign step_due  = moving && unit_tick && (delay_cnt <= 8'h01);

  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
      unit_cnt <= 12'h000;
    else if (!moving || unit_tick)
      unit_cnt <= 12'h000;
    else
      unit_cnt <= unit_cnt + 12'h001;
  end

  // reload with slot or idle delay after each step
  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
      delay_cnt <= 8'h00;
    else if (step_go)
      delay_cnt <= slot_empty ? idle_slot_delay : slot_delay;
    else if (moving && unit_tick && delay_cnt != 8'h00)
      delay_cnt <= delay_cnt - 8'h01;
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer walk
  logic at_rest;
  logic wake_ok;
  assign at_rest = (pos == 5'h00) || (pos == ptrs.partial_down_ptr);
  assign wake_ok = (state == ST_HOLD) && at_rest && wakeup_in;
  assign step_go = step_due;

  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state         <= ST_HOLD;
      pos           <= 5'h00;
      target        <= 5'h00;
      shutdown_pend <= 1'b0;
      reload_delays <= 1'b0;
    end
    else
    begin
      reload_delays <= 1'b0;
      if (ctrl[seq_pkg::CTRL_SHUTDOWN])
        shutdown_pend <= 1'b1;
      case (state)
        ST_HOLD:
        begin
          if (dom1_en && (ctrl[seq_pkg::CTRL_AUTO_BOOT] ||
              dom1_pin_in || wake_ok || ctrl[seq_pkg::CTRL_DOM1]))
          begin
            state         <= ST_UP;
            target        <= want;
            reload_delays <= 1'b1;
          end
        end
        ST_IDLE:
        begin
          if (shutdown_pend || want < pos)
          begin
            state  <= ST_DOWN;
            target <= shutdown_pend ? 5'h00 : want;
          end
          else if (want > pos)
          begin
            state  <= ST_UP;
            target <= want;
          end
        end
        ST_UP:
        begin
          if (step_go)
          begin
            if (pos >= target)
              state <= ST_IDLE;
            else
              pos <= pos + 5'h01;
          end
        end
        ST_DOWN:
        begin
          if (step_go)
          begin
            if (pos <= target)
            begin
              state <= shutdown_pend ? ST_RESET :
                       (pos == 5'h00 || pos == ptrs.partial_down_ptr) ?
                       ST_HOLD : ST_IDLE;
              shutdown_pend <= 1'b0;
            end
            else
              pos <= pos - 5'h01;
          end
        end
        ST_RESET:
          state <= ST_RESET; // only a reset leaves
        default:
          state <= ST_HOLD;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-id actions when a slot is processed
  logic slot_live;
  // a partial power-down stops short of its end slot, which stays on
  assign slot_live = step_go &&
                     (pos != 5'h00 || ctrl[seq_pkg::CTRL_DEF_SLOT]) &&
                     !(state == ST_DOWN && pos == target &&
                       pos != 5'h00);

  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_enable_out     <= 11'h000;
      reg_vsel_sleep_out <= 11'h000;
      gpo_out            <= 5'h00;
      pd_active_out      <= 1'b0;
    end
    else if (slot_live)
    begin
      for (int i = 0; i < seq_pkg::NUM_REGS; i++)
      begin
        if (hit[i] && !pin_ctl[i])
        begin
          if (state == ST_UP)
          begin
            if (seq_ctl[i] || pos != 5'h00)
              reg_enable_out[i] <= 1'b1;
            reg_vsel_sleep_out[i] <= 1'b0;
          end
          else if (keep_on[i])
            reg_vsel_sleep_out[i] <= 1'b1;
          else
            reg_enable_out[i] <= 1'b0;
        end
      end
      for (int k = 0; k < seq_pkg::NUM_GPO; k++)
      begin
        if (hit[seq_pkg::ID_GPO_BASE + 2 * k])
          gpo_out[k] <= (state == ST_UP);
        if (hit[seq_pkg::ID_GPO_BASE + 2 * k + 1])
          gpo_out[k] <= (state != ST_UP);
      end
      if (hit[seq_pkg::ID_PD])
        pd_active_out <= (state != ST_UP);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ready, done event, watchdog start
  logic finishing;
  assign finishing = step_go && moving &&
                     ((state == ST_UP && pos >= target) ||
                      (state == ST_DOWN && pos <= target));

  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ready_out          <= 1'b0;
      done_event_out     <= 1'b0;
      watchdog_start_out <= 1'b0;
    end
    else
    begin
      done_event_out     <= finishing &&
                            ctrl[seq_pkg::CTRL_DONE_EN];
      watchdog_start_out <= finishing && state == ST_UP &&
                            pos == ptrs.dom2_end;
      if (finishing)
        ready_out <= 1'b0;
      else if (moving)
        ready_out <= ctrl[seq_pkg::CTRL_FB_CFG];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // host reset: asserted before any power-down, timed release on power-up
  logic [16:0] rst_timer;
  logic        rst_timing;

  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
    begin
      host_reset_b_out <= 1'b0;
      rst_timer        <= 17'h00000;
      rst_timing       <= 1'b1;
      reset_mode_out   <= 1'b0;
    end
    else
    begin
      reset_mode_out <= (state == ST_RESET);
      if (state == ST_IDLE && (shutdown_pend || want < pos) &&
          ctrl[seq_pkg::CTRL_RES_BEFORE])
      begin
        host_reset_b_out <= 1'b0;
        rst_timing       <= 1'b0;
      end
      // any walk up counts as the next power-up, partial ones too
      else if (state == ST_UP && !host_reset_b_out && !rst_timing)
      begin
        rst_timing <= 1'b1;
        rst_timer  <= 17'h00000;
      end
      else if (rst_timing && !host_reset_b_out)
      begin
        if (rst_timer == 17'(seq_pkg::RESET_TIMER_CYC - 1))
          host_reset_b_out <= 1'b1;
        else
          rst_timer <= rst_timer + 17'h00001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after strobe
  always_ff @(posedge clock_in or negedge rst_b)
  begin
    if (!rst_b)
      rdata_out <= 32'h0000_0000;
    else if (rd_in)
    begin
      case (addr_in)
        seq_pkg::ADDR_CTRL:      rdata_out <= {22'h0, ctrl};
        seq_pkg::ADDR_PTRS:      rdata_out <= {12'h0, ptrs};
        seq_pkg::ADDR_TIMER:     rdata_out <= {16'h0, idle_slot_delay,
                                               slot_delay};
        seq_pkg::ADDR_TIMER_DEF: rdata_out <= {16'h0, idle_delay_def,
                                               slot_delay_def};
        seq_pkg::ADDR_SEQCTL:    rdata_out <= {21'h0, seq_ctl};
        seq_pkg::ADDR_KEEPON:    rdata_out <= {21'h0, keep_on};
        seq_pkg::ADDR_PINCTL:    rdata_out <= {21'h0, pin_ctl};
        seq_pkg::ADDR_STATUS:    rdata_out <= {24'h0, 3'(state), pos};
        seq_pkg::ADDR_OUTS:      rdata_out <= {5'h0, gpo_out,
                                               reg_vsel_sleep_out,
                                               reg_enable_out};
        default:
        begin
          if (addr_in[7:5] == seq_pkg::ADDR_SLOT_BASE[7:5])
            rdata_out <= {27'h0, slot_of[addr_in[4:0]]};
          else
            rdata_out <= 32'h0000_0000;
        end
      endcase
    end
    else
      rdata_out <= 32'h0000_0000;
  end

endmodule : supply_slot_sequencer

// ===== tb/host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// host side: domain enable pins, wakeup and the alive answer
module host_model (
  input  wire logic       clock_in,
  input  wire logic [2:0] want_dom_in,
  input  wire logic       want_wake_in,
  input  wire logic       slow_in,
  input  wire logic       wd_start_in,
  output logic [2:0]      dom_out,
  output logic            wake_out,
  output logic            alive_out
);
  int lag;

  initial
  begin
    dom_out   = 3'h0;
    wake_out  = 1'b0;
    alive_out = 1'b0;
    lag       = 0;
  end

  // slow mode holds a new level back seven cycles, like a busy host
  always @(posedge clock_in)
  begin
    if (want_dom_in != dom_out)
    begin
      if (!slow_in || lag == 7)
      begin
        dom_out <= want_dom_in;
        lag     <= 0;
      end
      else
        lag <= lag + 1;
    end
    wake_out  <= want_wake_in;
    alive_out <= wd_start_in;
  end
endmodule : host_model

// ===== tb/seq_asserts.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module seq_asserts (
  input wire logic        clock_in,
  input wire logic        rst_b_in,
  input wire logic [7:0]  addr_in,
  input wire logic        rd_in,
  input wire logic        dom3_pin_in,
  input wire logic [31:0] rdata_out,
  input wire logic [10:0] reg_enable_out,
  input wire logic [4:0]  gpo_out,
  input wire logic        ready_out,
  input wire logic        done_event_out,
  input wire logic        host_reset_b_out,
  input wire logic        watchdog_start_out,
  input wire logic        reset_mode_out
);
  localparam int RST_CYC = seq_pkg::RESET_TIMER_CYC;
  logic [17:0] since_rst;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);

  // saturating so a long run cannot wrap back under the limit
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      since_rst <= '0;
    else if (since_rst != '1)
      since_rst <= since_rst + 18'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_done_pulse;
    done_event_out |=> !done_event_out;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done event longer than one cycle");
  property p_rdata_idle;
    !rd_in |=> rdata_out == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside the answer cycle");
  property p_unmapped;
    (rd_in && addr_in == 8'h10) |=> rdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_wd_pulse;
    watchdog_start_out |=> !watchdog_start_out;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse)
    else $error("watchdog start longer than one cycle");
  property p_wd_ready;
    (watchdog_start_out && !dom3_pin_in) |-> ##[0:2] !ready_out;
  endproperty
  a_wd_ready: assert property (p_wd_ready)
    else $error("ready held at domain2 end");
  property p_rmode_hold;
    reset_mode_out |=> reset_mode_out;
  endproperty
  a_rmode_hold: assert property (p_rmode_hold)
    else $error("reset mode dropped");
  property p_rmode_gpo;
    $rose(reset_mode_out) |-> gpo_out == 5'h00;
  endproperty
  a_rmode_gpo: assert property (p_rmode_gpo)
    else $error("reset mode before full power-down");
  property p_host_reset;
    since_rst < 18'(RST_CYC) |-> !host_reset_b_out;
  endproperty
  a_host_reset: assert property (p_host_reset)
    else $error("host reset released before its timer");
  property p_down_ready;
    (($past(reg_enable_out) & ~reg_enable_out) != 11'h0)
      |-> (ready_out || $past(ready_out));
  endproperty
  a_down_ready: assert property (p_down_ready)
    else $error("supply switched off without ready");

  c_done: cover property (done_event_out);
  c_wd: cover property (watchdog_start_out);
  c_rmode: cover property ($rose(reset_mode_out));
endmodule : seq_asserts

bind supply_slot_sequencer seq_asserts seq_asserts_i (
  .clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
  .rd_in(rd_in), .dom3_pin_in(dom3_pin_in), .rdata_out(rdata_out),
  .reg_enable_out(reg_enable_out), .gpo_out(gpo_out),
  .ready_out(ready_out), .done_event_out(done_event_out),
  .host_reset_b_out(host_reset_b_out),
  .watchdog_start_out(watchdog_start_out),
  .reset_mode_out(reset_mode_out)
);

// ===== tb/tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module tb_top;
  logic        clock_in;
  logic        rst_b_in;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in;
  logic        wr_in;
  logic        rd_in;
  logic [2:0]  want_dom;
  logic        want_wake;
  logic        slow;
  logic [2:0]  dom_pins;
  logic        wake;
  logic        alive;
  logic [31:0] rdata_out;
  logic [10:0] reg_enable_out;
  logic [10:0] reg_vsel_sleep_out;
  logic [4:0]  gpo_out;
  logic        pd_active_out;
  logic        ready_out;
  logic        done_event_out;
  logic        host_reset_b_out;
  logic        watchdog_start_out;
  logic        reset_mode_out;
  logic [1:0]  seen;
  logic [31:0] d;
  logic [7:0]  ids [8] = '{8'd0, 8'd1, 8'd2, 8'd3, 8'd6, 8'd7, 8'd11,
                           8'd22};
  logic [31:0] slots [8] = '{0, 1, 1, 3, 3, 1, 3, 3};
  int          fails;
  int          checks;

  supply_slot_sequencer supply_slot_sequencer_i (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .dom1_pin_in(dom_pins[0]), .dom2_pin_in(dom_pins[1]),
    .dom3_pin_in(dom_pins[2]), .wakeup_in(wake), .alive_in(alive),
    .rdata_out(rdata_out), .reg_enable_out(reg_enable_out),
    .reg_vsel_sleep_out(reg_vsel_sleep_out), .gpo_out(gpo_out),
    .pd_active_out(pd_active_out), .ready_out(ready_out),
    .done_event_out(done_event_out), .host_reset_b_out(host_reset_b_out),
    .watchdog_start_out(watchdog_start_out),
    .reset_mode_out(reset_mode_out)
  );

  host_model host_model_i (
    .clock_in(clock_in), .want_dom_in(want_dom), .want_wake_in(want_wake),
    .slow_in(slow), .wd_start_in(watchdog_start_out), .dom_out(dom_pins),
    .wake_out(wake), .alive_out(alive)
  );

  initial clock_in = 1'b0;
  always #5 clock_in = ~clock_in;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] got,
                     input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in    <= 1'b0;
  endtask : wr

  // answer stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in   <= 1'b0;
    #1;
    v = rdata_out;
  endtask : rd

  // follow one walk to its done pulse; slots are 3200 cycles apart
  task automatic walk(output logic [1:0] saw);
    logic found;
    saw   = 2'b00;
    found = 1'b0;
    for (int i = 0; i < 16000 && !found; i++)
    begin
      @(negedge clock_in);
      saw[0] = saw[0] | (ready_out === 1'b1);
      saw[1] = saw[1] | (watchdog_start_out === 1'b1);
      found  = (done_event_out === 1'b1);
    end
    chk("walk_done", 32'(found), 32'h1);
    repeat (2) @(negedge clock_in);
  endtask : walk

  task automatic results;
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // a full run is about 35000 cycles
  initial
  begin
    #900000;
    fails++;
    results();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    fails     = 0;
    checks    = 0;
    rst_b_in  = 1'b0;
    addr_in   = 8'h00;
    wdata_in  = 32'h0;
    wr_in     = 1'b0;
    rd_in     = 1'b0;
    want_dom  = 3'h0;
    want_wake = 1'b0;
    slow      = 1'b0;
    repeat (4) @(posedge clock_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rd(seq_pkg::ADDR_CTRL, d);
    chk("ctrl_reset", d, 32'h018);
    rd(8'h10, d);
    chk("unmapped", d, 32'h0);
    chk("host_reset_b", 32'(host_reset_b_out), 32'h0);
    // shortest delay unit keeps each slot at 3200 cycles
    wr(seq_pkg::ADDR_TIMER, 32'h0202);
    wr(seq_pkg::ADDR_TIMER_DEF, 32'h0101);
    wr(seq_pkg::ADDR_PTRS, {12'h0, 5'h01, 5'h02, 5'h03, 5'h01});
    foreach (ids[k])
      wr(seq_pkg::ADDR_SLOT_BASE + ids[k], slots[k]);
    wr(seq_pkg::ADDR_SEQCTL, 32'h0cf);
    wr(seq_pkg::ADDR_KEEPON, 32'h040);
    wr(seq_pkg::ADDR_PINCTL, 32'h080);
    wr(seq_pkg::ADDR_CTRL, 32'h398);
    rd(seq_pkg::ADDR_KEEPON, d);
    chk("keepon_rb", d, 32'h040);
    // domain1 up
    want_dom <= 3'b001;
    walk(seen);
    chk("ready_up", 32'(seen[0]), 32'h1);
    chk("ready_dom1", 32'(ready_out), 32'h0);
    chk("en_dom1", 32'(reg_enable_out), 32'h007);
    chk("vsel_dom1", 32'(reg_vsel_sleep_out), 32'h0);
    rd(seq_pkg::ADDR_TIMER, d);
    chk("timer_reload", d, 32'h0101);
    // domain2 holds only an empty slot; host answers slowly
    slow     <= 1'b1;
    want_dom <= 3'b011;
    walk(seen);
    chk("wd_start", 32'(seen[1]), 32'h1);
    chk("ready_dom2", 32'(ready_out), 32'h0);
    chk("en_dummy", 32'(reg_enable_out), 32'h007);
    slow     <= 1'b0;
    want_dom <= 3'b111;
    walk(seen);
    chk("ready_dom3", 32'(seen[0]), 32'h1);
    chk("en_dom3", 32'(reg_enable_out), 32'h04f);
    chk("gpo_up", 32'(gpo_out), 32'h01);
    chk("pd_up", 32'(pd_active_out), 32'h0);
    // domain3 off: back to the domain2 end only
    want_dom <= 3'b011;
    walk(seen);
    chk("ready_down", 32'(seen[0]), 32'h1);
    chk("en_down3", 32'(reg_enable_out), 32'h047);
    chk("vsel_down3", 32'(reg_vsel_sleep_out), 32'h040);
    chk("gpo_down", 32'(gpo_out), 32'h00);
    chk("pd_down", 32'(pd_active_out), 32'h1);
    rd(seq_pkg::ADDR_STATUS, d);
    chk("pos_dom2", d & 32'h1f, 32'h02);
    // wakeup while running must not move the walk
    want_wake <= 1'b1;
    repeat (4) @(posedge clock_in);
    want_wake <= 1'b0;
    repeat (4) @(posedge clock_in);
    rd(seq_pkg::ADDR_STATUS, d);
    chk("pos_wake", d & 32'h1f, 32'h02);
    wr(seq_pkg::ADDR_CTRL, 32'h3d8);
    walk(seen);
    chk("en_shut", 32'(reg_enable_out), 32'h040);
    chk("reset_mode", 32'(reset_mode_out), 32'h1);
    rd(seq_pkg::ADDR_STATUS, d);
    chk("pos_shut", d & 32'h1f, 32'h00);
    results();
  end
endmodule : tb_top
